// *** logic/mcec_machine_check_error_coder.sv ***
// How it works
// RULE1 - Three code layouts: TLB, hierarchy and bus errors
// RULE2 - Access class: instruction 00, data 01, generic 10
// RULE3 - Unknown instruction-or-data access reports generic class
// RULE4 - Level: 00, 01, 10, generic 11
// RULE5 - Unknown level reports generic level code
// RULE6 - Request kinds numbered 0000 through 1000
// RULE7 - Unknown type gives generic error; unknown source generic read/write
// RULE8 - Eviction and snoop only for cache errors
// RULE9 - Participation: originator 00, answering 01, third party 10, generic 11
// RULE10 - Timeout bit is 1 when timed out, else 0
// RULE11 - Space: memory 00, IO 10, other 11; reserved 01 never emitted
// RULE12 - Machine-check trap uses vector 18
// RULE13 - Capability count field holds bank count; bank zero at 400H
// RULE14 - Logged flag per bank; clear means bank holds nothing
// RULE15 - Multiple-error flag set on second error in a bank
// RULE16 - Uncorrected flag per bank tells hardware-corrected or not
// RULE17 - Restart-IP flag set only if resume at saved pointer works
// RULE18 - Error-IP flag set for related instruction, else cleared
// RULE19 - Check-in-progress set when trap is raised
// RULE20 - Error while check in progress enters shutdown, no trap; the code shuts down on uncorrected errors only, corrected ones are just logged
// RULE21 - Handler clears check-in-progress before returning
// RULE22 - Firmware enables bus init drive and observe
// RULE23 - Detected error writes 16-bit code and sets logged flag
// RULE24 - Sub-fields placed at layout bit positions, leftmost bit 15
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none

module mcec_machine_check_error_coder (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire mcec_pkg::mcec_apb_req_t apbReq,
  output mcec_pkg::mcec_apb_rsp_t apbRsp,
  input wire logic errValid,
  input wire mcec_pkg::mcec_error_t errInfo,
  output logic machineCheckTrap,
  output logic [7:0] trapVector,
  output logic shutdownState,
  output logic busInitDriveEn,
  output logic busInitObserveEn
);
  import mcec_pkg::*;

  // Ports:
  //   apbReq/apbRsp    register port, one wait state per transfer
  //   errValid         one-cycle pulse per detected error
  //   errInfo          sub-fields, bank and recovery hints of that error
  //   machineCheckTrap one-cycle trap request
  //   trapVector       trap vector, 0 during reset
  //   shutdownState    recursion shutdown, held until reset
  //   busInitDriveEn   copy of control bit 1
  //   busInitObserveEn copy of control bit 2
  // All outputs come from flip-flops; all inputs are on mclk,
  // so none of them passes a synchroniser.

  // Sub-field layouts, bit 15 on the left:
  //   TLB       0000 0000 0001 cc ll
  //   hierarchy 0000 0001 request_kind cc ll
  //   bus       0000 1 pp t request_kind ss ll
  // cc access class, ll level, request_kind request kind,
  // pp participation role, t timeout, ss space kind.
  // Class, level, request kind and space are cleaned up before packing so that
  // software never sees a reserved or illegal value.

  // Access class: unknown or out-of-range becomes generic
  function automatic logic [1:0] cleanClass(input logic known, input logic [1:0] c);
    logic [1:0] r;
    r = known ? c : MCEC_CLASS_GENERIC; // RULE3
    if (r == 2'(MCEC_CLASS_GENERIC + 2'h1)) begin
      r = MCEC_CLASS_GENERIC; // RULE2
    end
    return r;
  endfunction

  // Hierarchy level: unknown becomes the generic level
  function automatic logic [1:0] cleanLevel(input logic known, input logic [1:0] l);
    return known ? l : MCEC_LEVEL_GENERIC; // RULE4 RULE5
  endfunction

  // Request kind: unused codes and cache-only kinds elsewhere become generic error
  function automatic logic [3:0] cleanRequest(input mcec_error_kind_t k, input logic [3:0] q);
    logic [3:0] r;
    r = q;
    if (r > MCEC_REQ_SNOOP) begin
      r = MCEC_REQ_GENERIC_ERR; // RULE7
    end
    if (k != MCEC_KIND_HIER && (r == MCEC_REQ_EVICTION || r == MCEC_REQ_SNOOP)) begin
      r = MCEC_REQ_GENERIC_ERR; // RULE8
    end
    return r;
  endfunction

  // Space kind: the reserved code is never emitted
  function automatic logic [1:0] cleanSpace(input logic [1:0] s);
    return (s == MCEC_SPACE_RESERVED) ? MCEC_SPACE_OTHER : s; // RULE11
  endfunction

  // Compound code builder with sub-field sanitising.
  // Kind code 3 is never driven by the core; it reports unclassified.
  function automatic logic [15:0] encodeCode(input mcec_error_t e);
    logic [1:0] cls;
    logic [1:0] lvl;
    logic [3:0] req;
    logic [1:0] spc;
    logic [15:0] code;
    cls = cleanClass(e.classKnown, e.accessClass);
    lvl = cleanLevel(e.levelKnown, e.hierarchyLevel);
    req = cleanRequest(e.kind, e.requestKind);
    spc = cleanSpace(e.spaceKind);
    case (e.kind)
      MCEC_KIND_TLB: begin
        code = {TLB_PREFIX, cls, lvl}; // RULE1 RULE24
      end
      MCEC_KIND_HIER: begin
        code = {HIER_PREFIX, req, cls, lvl}; // RULE1 RULE6 RULE24
      end
      MCEC_KIND_BUS: begin
        code = {BUS_PREFIX, e.participationRole, e.timedOut, req, spc, lvl}; // RULE9 RULE10
      end
      default: begin
        code = 16'h0001;
      end
    endcase
    return code;
  endfunction

  // True for an aligned word inside the bank status window
  function automatic logic isBankAddr(input logic [11:0] a);
    return (a >= BANK_STATUS_BASE) && (a < BANK_STATUS_BASE + 12'(4 * BANK_COUNT))
      && (a[1:0] == 2'h0);
  endfunction

  // Addresses that accept a write
  function automatic logic isWritableAddr(input logic [11:0] a);
    return isBankAddr(a) || (a == GLOBAL_STATUS_ADDR) || (a == BANK_CONTROL_ADDR);
  endfunction

  // Addresses that answer a read
  function automatic logic isMappedAddr(input logic [11:0] a);
    return isWritableAddr(a) || (a == GLOBAL_CAPABILITY_ADDR) || (a == TRAP_VECTOR_ADDR);
  endfunction

  // Register map, byte addresses on the APB port:
  //   000 capability, read only: bank count in [7:0]
  //   004 global status: [0] restart ok, [1] error pointer related,
  //       [2] check in progress, all read/write; [3] shutdown, read only
  //   008 bank control: [0] check enable, [1] bus init drive,
  //       [2] bus init observe
  //   00C trap vector, read only
  //   400 + 4*i bank i status, full word read/write:
  //       [15:0] code, [31] logged, [30] multiple,
  //       [29] uncorrected, [28] context corrupt
  // A write to a read-only or unmapped word, or a read of an
  // unmapped word, answers with pslverr and changes nothing.

  // Bank words, control word, global flags and APB answer
  logic [31:0] bankStatus_r [BANK_COUNT];
  logic [31:0] bankControl_r;
  logic restartOk_r;
  logic errIpRelated_r;
  logic inProgress_r;
  logic shutdown_r;
  logic trap_r;
  logic [31:0] rdata_r;
  logic ready_r;
  logic slverr_r;
  logic wrStrobe;
  logic rdStrobe;
  logic acceptErr;
  logic [BANK_IDX_W-1:0] wrBank;
  logic [15:0] newCode;
  logic uncorrErr;
  logic takeTrap;
  logic enterShutdown;
  logic statusWr;
  logic controlWr;

  // Access strobes fire in the first access cycle only, one wait state before pready
  assign wrStrobe = apbReq.psel && apbReq.penable && apbReq.pwrite && !ready_r;
  assign rdStrobe = apbReq.psel && apbReq.penable && !apbReq.pwrite && !ready_r;
  assign acceptErr = errValid && bankControl_r[CHECK_ENABLE_BIT] && !shutdown_r;
  assign wrBank = apbReq.paddr[2 +: BANK_IDX_W];
  assign newCode = encodeCode(errInfo);

  // Error port timing: errValid is taken at an edge when checking is
  // enabled and the block is not shut down; the bank, the flags and
  // the trap pulse all change at that same edge. Corrected errors are
  // logged but never trap.
  // An accepted uncorrected error either traps or, while a check is
  // still in progress, is a recursion and shuts down.
  // An accepted error in the same cycle as a software write wins.
  assign uncorrErr = acceptErr && !errInfo.corrected;
  assign takeTrap = uncorrErr && !inProgress_r;
  assign enterShutdown = uncorrErr && inProgress_r;
  assign statusWr = wrStrobe && apbReq.paddr == GLOBAL_STATUS_ADDR;
  assign controlWr = wrStrobe && apbReq.paddr == BANK_CONTROL_ADDR;

  // Per-bank status logging; hardware set wins over software clear.
  // A second error into a logged bank marks it multiple and overwrites
  // the code, so the handler sees the newest cause with the warning.
  // Software clears a bank by writing zero to its whole word.
  genvar b;
  generate
    for (b = 0; b < BANK_COUNT; b++) begin : gBank
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          bankStatus_r[b] <= 32'h0000_0000;
        end else if (acceptErr && errInfo.bank == BANK_IDX_W'(b)) begin
          bankStatus_r[b][15:0] <= newCode; // RULE23
          bankStatus_r[b][LOGGED_BIT] <= 1'b1; // RULE14 RULE23
          bankStatus_r[b][MULTI_BIT] <= bankStatus_r[b][LOGGED_BIT] |
            bankStatus_r[b][MULTI_BIT]; // RULE15
          bankStatus_r[b][UNCORR_BIT] <= !errInfo.corrected; // RULE16
          bankStatus_r[b][CORRUPT_BIT] <= errInfo.contextCorrupt;
        end else if (wrStrobe && isBankAddr(apbReq.paddr) && wrBank == BANK_IDX_W'(b)) begin
          bankStatus_r[b] <= apbReq.pwdata;
        end
      end
    end
  endgenerate

  // Bank control: check enable and bus init drive/observe.
  // Checking stays off after reset until firmware sets bit 0;
  // unused bits read back as zero.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bankControl_r <= BANK_CONTROL_RESET;
    end else if (controlWr) begin
      bankControl_r <= {29'h0, apbReq.pwdata[2:0]}; // RULE22
    end
  end

  // Trap request: one-cycle pulse for each uncorrected error outside a check
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      trap_r <= 1'b0;
    end else begin
      trap_r <= takeTrap; // RULE19
    end
  end

  // Check in progress: set with each trap, cleared by software or by reset.
  // An accepted uncorrected error in the cycle of a clearing write still sets it.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      inProgress_r <= 1'b0;
    end else if (takeTrap) begin
      inProgress_r <= 1'b1; // RULE19
    end else if (statusWr && !uncorrErr) begin
      inProgress_r <= apbReq.pwdata[IN_PROGRESS_BIT]; // RULE21
    end
  end

  // Shutdown on recursion; only reset leaves it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      shutdown_r <= 1'b0;
    end else if (enterShutdown) begin
      shutdown_r <= 1'b1; // RULE20
    end
  end

  // Restart and error-pointer flags, captured with each trap.
  // A corrupt context can never be restarted, whatever the core says.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      restartOk_r <= 1'b0;
      errIpRelated_r <= 1'b0;
    end else if (takeTrap) begin
      restartOk_r <= errInfo.restartOk && !errInfo.contextCorrupt; // RULE17
      errIpRelated_r <= errInfo.errorIpRelated; // RULE18
    end else if (statusWr && !uncorrErr) begin
      restartOk_r <= apbReq.pwdata[RESTART_OK_BIT];
      errIpRelated_r <= apbReq.pwdata[ERR_IP_BIT];
    end
  end

  // APB timing, one wait state:
  //   c0 setup, psel high
  //   c1 first access edge: a write lands, read data is captured
  //   c2 pready high with prdata and pslverr, then the master releases
  // The strobes fire only on the first access edge, so a master that
  // holds penable into the answer cycle cannot write twice.

  // Ready: high for one cycle after the first access edge
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= apbReq.psel && apbReq.penable && !ready_r;
    end
  end

  // Error answer for words that refuse the access
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      slverr_r <= 1'b0;
    end else if (rdStrobe) begin
      slverr_r <= !isMappedAddr(apbReq.paddr);
    end else if (wrStrobe) begin
      slverr_r <= !isWritableAddr(apbReq.paddr);
    end else begin
      slverr_r <= 1'b0;
    end
  end

  // Read data mux; zero outside a read answer
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (rdStrobe && isBankAddr(apbReq.paddr)) begin
      rdata_r <= bankStatus_r[wrBank];
    end else if (rdStrobe) begin
      case (apbReq.paddr)
        GLOBAL_CAPABILITY_ADDR: begin
          rdata_r <= {24'h0, BANK_COUNT_VAL}; // RULE13
        end
        GLOBAL_STATUS_ADDR: begin
          rdata_r <= {28'h0, shutdown_r, inProgress_r, errIpRelated_r, restartOk_r};
        end
        BANK_CONTROL_ADDR: begin
          rdata_r <= bankControl_r;
        end
        TRAP_VECTOR_ADDR: begin
          rdata_r <= {24'h0, MACHINE_CHECK_VECTOR}; // RULE12
        end
        default: begin
          rdata_r <= 32'h0000_0000;
        end
      endcase
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  // Registered side outputs. The vector reads 0 during reset and the
  // fixed trap vector from the first edge after it; the bus init
  // enables follow the control register one cycle late.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      trapVector <= 8'h00;
      busInitDriveEn <= 1'b0;
      busInitObserveEn <= 1'b0;
    end else begin
      trapVector <= MACHINE_CHECK_VECTOR; // RULE12
      busInitDriveEn <= bankControl_r[BUS_INIT_DRIVE_BIT];
      busInitObserveEn <= bankControl_r[BUS_INIT_OBSERVE_BIT];
    end
  end

  // Outputs taken straight from their flip-flops; the trap pulse
  // lasts one cycle, shutdown holds until reset, and the APB answer
  // stands for the single cycle in which pready is high.
  assign machineCheckTrap = trap_r;
  assign shutdownState = shutdown_r;
  assign apbRsp = '{pready: ready_r, pslverr: slverr_r, prdata: rdata_r};

endmodule

`default_nettype wire

// *** logic/mcec_pkg.sv ***
package mcec_pkg;

  // Register byte addresses on the APB port
  localparam logic [11:0] GLOBAL_CAPABILITY_ADDR = 12'h000;
  localparam logic [11:0] GLOBAL_STATUS_ADDR = 12'h004;
  localparam logic [11:0] BANK_CONTROL_ADDR = 12'h008;
  localparam logic [11:0] TRAP_VECTOR_ADDR = 12'h00C;
  localparam logic [11:0] BANK_STATUS_BASE = 12'h400;

  // Bank organisation
  localparam int BANK_COUNT = 4;
  localparam int BANK_IDX_W = 2;
  localparam logic [7:0] BANK_COUNT_VAL = 8'h04;

  // Machine-check trap vector
  localparam logic [7:0] MACHINE_CHECK_VECTOR = 8'h12;

  // Compound code prefixes
  localparam logic [11:0] TLB_PREFIX = 12'h001;
  localparam logic [7:0] HIER_PREFIX = 8'h01;
  localparam logic [4:0] BUS_PREFIX = 5'h01;

  // Bank status field positions
  localparam int LOGGED_BIT = 31;
  localparam int MULTI_BIT = 30;
  localparam int UNCORR_BIT = 29;
  localparam int CORRUPT_BIT = 28;

  // Global status field positions
  localparam int RESTART_OK_BIT = 0;
  localparam int ERR_IP_BIT = 1;
  localparam int IN_PROGRESS_BIT = 2;
  localparam int SHUTDOWN_BIT = 3;

  // Bank control field positions
  localparam int CHECK_ENABLE_BIT = 0;
  localparam int BUS_INIT_DRIVE_BIT = 1;
  localparam int BUS_INIT_OBSERVE_BIT = 2;
  localparam logic [31:0] BANK_CONTROL_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    MCEC_CLASS_INSTR = 2'h0,
    MCEC_CLASS_DATA = 2'h1,
    MCEC_CLASS_GENERIC = 2'h2
  } mcec_access_class_t;

  typedef enum logic [1:0] {
    MCEC_LEVEL_0 = 2'h0,
    MCEC_LEVEL_1 = 2'h1,
    MCEC_LEVEL_2 = 2'h2,
    MCEC_LEVEL_GENERIC = 2'h3
  } mcec_hierarchy_level_t;

  typedef enum logic [3:0] {
    MCEC_REQ_GENERIC_ERR = 4'h0,
    MCEC_REQ_GENERIC_RD = 4'h1,
    MCEC_REQ_GENERIC_WR = 4'h2,
    MCEC_REQ_DATA_READ = 4'h3,
    MCEC_REQ_DATA_STORE = 4'h4,
    MCEC_REQ_INSTR_FETCH = 4'h5,
    MCEC_REQ_PREFETCH = 4'h6,
    MCEC_REQ_EVICTION = 4'h7,
    MCEC_REQ_SNOOP = 4'h8
  } mcec_request_kind_t;

  typedef enum logic [1:0] {
    MCEC_ROLE_ORIGINATOR = 2'h0,
    MCEC_ROLE_ANSWERING = 2'h1,
    MCEC_ROLE_THIRD_PARTY = 2'h2,
    MCEC_ROLE_GENERIC = 2'h3
  } mcec_participation_role_t;

  typedef enum logic [1:0] {
    MCEC_SPACE_MEMORY = 2'h0,
    MCEC_SPACE_RESERVED = 2'h1,
    MCEC_SPACE_IO = 2'h2,
    MCEC_SPACE_OTHER = 2'h3
  } mcec_space_kind_t;

  typedef enum logic [1:0] {
    MCEC_KIND_TLB = 2'h0,
    MCEC_KIND_HIER = 2'h1,
    MCEC_KIND_BUS = 2'h2
  } mcec_error_kind_t;

  // One detected error as delivered by the core
  typedef struct packed {
    mcec_error_kind_t kind;
    logic classKnown;
    mcec_access_class_t accessClass;
    logic levelKnown;
    mcec_hierarchy_level_t hierarchyLevel;
    mcec_request_kind_t requestKind;
    mcec_participation_role_t participationRole;
    logic timedOut;
    mcec_space_kind_t spaceKind;
    logic corrected;
    logic contextCorrupt;
    logic restartOk;
    logic errorIpRelated;
    logic [BANK_IDX_W-1:0] bank;
  } mcec_error_t;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mcec_apb_req_t;

  // APB answer to the master
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } mcec_apb_rsp_t;

endpackage

// *** test/mcec_coder_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
module mcec_coder_chk (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire mcec_pkg::mcec_apb_req_t apbReq,
  input wire mcec_pkg::mcec_apb_rsp_t apbRsp,
  input wire logic errValid,
  input wire mcec_pkg::mcec_error_t errInfo,
  input wire logic machineCheckTrap,
  input wire logic [7:0] trapVector,
  input wire logic shutdownState,
  input wire logic busInitDriveEn,
  input wire logic busInitObserveEn
);
  import mcec_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Trap side
  property p_vector; !$past(sys_rst) |-> trapVector == 8'h12; endproperty
  property p_trap_pulse; machineCheckTrap |=> !machineCheckTrap; endproperty
  property p_trap_cause; machineCheckTrap |-> $past(errValid && !errInfo.corrected); endproperty
  property p_shut_hold; shutdownState |=> shutdownState; endproperty
  property p_no_trap_shut; shutdownState |-> !machineCheckTrap; endproperty
  property p_shut_cause; $rose(shutdownState) |-> $past(errValid && !errInfo.corrected);
  endproperty
  // Register port side
  property p_pready; apbReq.psel && apbReq.penable && !apbRsp.pready |=> apbRsp.pready;
  endproperty
  property p_err_ready; apbRsp.pslverr |-> apbRsp.pready; endproperty
  property p_init_en; $changed({busInitDriveEn, busInitObserveEn}) |->
    $past(apbReq.psel && apbReq.pwrite, 1) || $past(apbReq.psel && apbReq.pwrite, 2);
  endproperty
  a_vector: assert property (p_vector) else $error("trap vector wrong");
  a_trap_pulse: assert property (p_trap_pulse) else $error("trap too long");
  a_trap_cause: assert property (p_trap_cause) else $error("trap without cause");
  a_shut_hold: assert property (p_shut_hold) else $error("shutdown left");
  a_no_trap_shut: assert property (p_no_trap_shut) else $error("trap in shutdown");
  a_shut_cause: assert property (p_shut_cause) else $error("shutdown uncaused");
  a_pready: assert property (p_pready) else $error("pready late");
  a_err_ready: assert property (p_err_ready) else $error("pslverr alone");
  a_init_en: assert property (p_init_en) else $error("init enable moved");
  c_trap: cover property (machineCheckTrap);
  c_shut: cover property ($rose(shutdownState));
  c_slverr: cover property (apbRsp.pslverr);
endmodule
`default_nettype wire

// *** test/mcec_handler_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module mcec_handler_model (
  input wire logic mclk,
  output mcec_pkg::mcec_apb_req_t apbReq,
  input wire mcec_pkg::mcec_apb_rsp_t apbRsp
);
  import mcec_pkg::*;
  initial apbReq = '0;
  // One transfer, request held until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge mclk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (apbRsp.pready !== 1'b1); // Only the bench watchdog ends a wait
    q = apbRsp.prdata;
    e = apbRsp.pslverr;
    apbReq <= '{1'b0, 1'b0, ~w, ~a, ~d}; // Released lines show no stale value
    @(posedge mclk);
  endtask
  // Boot firmware turns checking and init drive/observe on
  task automatic firmware_init();
    logic [31:0] q;
    logic e;
    xfer(1'b1, BANK_CONTROL_ADDR, 32'h0000_0007, q, e);
  endtask
  // Handler clears the in-progress flag before returning
  task automatic handler_return();
    logic [31:0] q;
    logic e;
    xfer(1'b1, GLOBAL_STATUS_ADDR, 32'h0, q, e);
  endtask
endmodule
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import mcec_pkg::*;
  logic mclk, sys_rst, errValid, trap, shutdownState, driveEn, observeEn, e;
  logic [7:0] trapVector;
  logic [31:0] q;
  mcec_apb_req_t apbReq;
  mcec_apb_rsp_t apbRsp;
  mcec_error_t errInfo;
  int n_errors, check_count, trapCount;
  mcec_machine_check_error_coder dut (.mclk(mclk), .sys_rst(sys_rst), .apbReq(apbReq),
    .apbRsp(apbRsp), .errValid(errValid), .errInfo(errInfo), .machineCheckTrap(trap),
    .trapVector(trapVector), .shutdownState(shutdownState), .busInitDriveEn(driveEn),
    .busInitObserveEn(observeEn));
  mcec_handler_model handler (.mclk(mclk), .apbReq(apbReq), .apbRsp(apbRsp));
  // Clock and trap pulse counter
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) if (trap === 1'b1) trapCount++;
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", s, x, g);
    end
  endtask
  function automatic mcec_error_t mk(input logic [16:0] f, input logic [5:0] g);
    return mcec_error_t'({f, g});
  endfunction
  task automatic rd(input logic [11:0] a);
    handler.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic inject(input mcec_error_t v);
    errInfo <= v;
    errValid <= 1'b1;
    @(posedge mclk);
    errValid <= 1'b0;
    errInfo <= ~v;
    repeat (3) @(posedge mclk);
  endtask
  // Corrected error into bank 0, code read back, bank cleared
  task automatic code_case(input logic [16:0] f, input logic [15:0] x);
    inject(mk(f, 6'b100000));
    rd(BANK_STATUS_BASE);
    chk("bank0 code", {16'h8000, x}, q);
    handler.xfer(1'b1, BANK_STATUS_BASE, 32'h0, q, e);
  endtask
  task automatic t_regs();
    rd(GLOBAL_CAPABILITY_ADDR);
    chk("bank count", 32'h4, {24'h0, q[7:0]});
    rd(TRAP_VECTOR_ADDR);
    chk("vector reg", 32'h12, {24'h0, q[7:0]});
    chk("vector pin", 32'h12, {24'h0, trapVector});
    rd(12'h0F0);
    chk("unmapped", 32'h1, {31'h0, e});
    handler.firmware_init();
    chk("init enables", 32'h3, {30'h0, driveEn, observeEn});
  endtask
  task automatic t_codes();
    code_case(17'b00_1_01_1_01_0000_00_0_00, 16'h0015);
    code_case(17'b00_0_00_0_00_0000_00_0_00, 16'h001B);
    code_case(17'b01_1_00_1_10_0101_00_0_00, 16'h0152);
    code_case(17'b01_1_10_1_00_1000_00_0_00, 16'h0188);
    code_case(17'b10_1_01_1_01_0100_10_1_10, 16'h0D49);
    code_case(17'b10_1_00_0_00_0111_00_0_01, 16'h080F);
    code_case(17'b10_1_00_1_00_0001_01_0_00, 16'h0A10);
    code_case(17'b10_1_00_1_10_0010_11_0_11, 16'h0E2E);
    for (int r = 0; r < 9; r++) begin
      code_case({5'b01_1_01, 3'b1_00, r[3:0], 5'b0}, {8'h01, r[3:0], 4'h4});
    end
  endtask
  task automatic t_trap();
    inject(mk(17'b01_1_00_1_01_0011_00_0_00, 6'b001101));
    chk("trap count", 32'h1, trapCount);
    rd(GLOBAL_STATUS_ADDR);
    chk("global", 32'h7, q);
    rd(BANK_STATUS_BASE + 12'h004);
    chk("bank1", 32'hA000_0131, q);
    inject(mk(17'b01_1_00_1_01_0011_00_0_00, 6'b100001));
    rd(BANK_STATUS_BASE + 12'h004);
    chk("multiple", 32'h3, {30'h0, q[31:30]});
    handler.handler_return();
    rd(GLOBAL_STATUS_ADDR);
    chk("cleared", 32'h0, q);
    inject(mk(17'b01_1_00_1_01_0011_00_0_00, 6'b011000));
    rd(GLOBAL_STATUS_ADDR);
    chk("corrupt", 32'h4, q);
    inject(mk(17'b01_1_00_1_01_0011_00_0_00, 6'b000000));
    chk("recursion", 32'h2, trapCount);
    chk("shutdown", 32'h1, {31'h0, shutdownState});
  endtask
  task automatic results();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    errValid = 1'b0;
    errInfo = '0;
    n_errors = 0;
    check_count = 0;
    trapCount = 0;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    t_regs();
    t_codes();
    t_trap();
    results();
  end
  // Watchdog
  initial begin
    #50000;
    n_errors++;
    results();
  end
endmodule
bind mcec_machine_check_error_coder mcec_coder_chk chk_i (.mclk(mclk), .sys_rst(sys_rst),
  .apbReq(apbReq), .apbRsp(apbRsp), .errValid(errValid), .errInfo(errInfo),
  .machineCheckTrap(machineCheckTrap), .trapVector(trapVector),
  .shutdownState(shutdownState), .busInitDriveEn(busInitDriveEn),
  .busInitObserveEn(busInitObserveEn));
`default_nettype wire
